//--- tidrb_regs.sv
`timescale 1ns/1ps
`include "tidrb_map.svh"
module tidrb_regs #(
  parameter bit WIDE_ID_SUPPORT = 1'b1,
  parameter logic [7:0] SHORT_ID_RESET = `TIDRB_SHORT_RESET,
  parameter logic [15:0] WIDE_ID_RESET = `TIDRB_WIDE_RESET
) (
  input wire logic mclk,
  input wire logic rst_n,
  input tidrb_pkg::tidrb_req_t req,
  output tidrb_pkg::tidrb_rsp_t rsp,
  output logic [7:0] short_node_id,
  output logic [15:0] wide_node_id,
  output logic [15:0] owner_node_id,
  output logic owner_locked,
  output logic wide_mode
);
  // ****************************************
  // decode
  // ****************************************
  // word index compare; low two address bits ignored
  function automatic logic hit(input logic [23:0] a, input logic [23:0] ofs);
    hit = (a[23:2] == ofs[23:2]);
  endfunction : hit

  // space classes follow the map's base offsets
  function automatic logic in_cap_space(input logic [23:0] a);
    in_cap_space = (a < `TIDRB_CAP_END);
  endfunction : in_cap_space

  function automatic logic in_csr_space(input logic [23:0] a);
    in_csr_space = (a >= `TIDRB_CAP_END) && (a < `TIDRB_EXT_BASE);
  endfunction : in_csr_space

  function automatic logic in_ext_space(input logic [23:0] a);
    in_ext_space = (a >= `TIDRB_EXT_BASE) && (a < `TIDRB_IMPL_BASE);
  endfunction : in_ext_space

  // implementation-defined space: read zero, writes dropped
  function automatic logic in_impl_space(input logic [23:0] a);
    in_impl_space = (a >= `TIDRB_IMPL_BASE);
  endfunction : in_impl_space

  // ****************************************
  // field helpers
  // ****************************************
  // vector bit 31-n holds big-endian bit n
  function automatic logic [31:0] feat_pack(input logic wide);
    feat_pack = 32'h0;
    feat_pack[`TIDRB_FEAT_WIDE_LSB] = wide;
  endfunction : feat_pack

  // reserved byte always packed as zero
  function automatic logic [31:0] node_pack(input logic [7:0] s, input logic [15:0] w);
    node_pack = {8'h00, s, w};
  endfunction : node_pack

  function automatic logic [31:0] owner_pack(input logic [15:0] id);
    owner_pack = {16'h0000, id};
  endfunction : owner_pack

  // only defined fields are taken from write data
  function automatic logic [7:0] node_short(input logic [31:0] d);
    node_short = d[`TIDRB_SHORT_LSB +: 8];
  endfunction : node_short

  function automatic logic [15:0] node_wide(input logic [31:0] d);
    node_wide = d[`TIDRB_WIDE_LSB +: 16];
  endfunction : node_wide

  function automatic logic [15:0] owner_field(input logic [31:0] d);
    owner_field = d[`TIDRB_OWNER_LSB +: 16];
  endfunction : owner_field

  logic hit_feat;
  logic hit_node;
  logic hit_owner;
  logic in_cap;
  logic hit_csr;
  logic hit_ext;
  logic hit_impl;
  logic resv_hit;
  logic [31:0] feat_word;
  logic [31:0] node_word;
  logic [31:0] owner_word;
  logic [31:0] rdata_next;
  logic [7:0] short_reg;
  logic [15:0] wide_reg;
  logic owner_wr;
  tidrb_pkg::tidrb_lock_t lock_state;

  assign hit_feat = hit(req.addr, `TIDRB_OFS_FEATURE);
  assign hit_node = hit(req.addr, `TIDRB_OFS_NODE_ID);
  assign hit_owner = hit(req.addr, `TIDRB_OFS_OWNER);
  assign in_cap = in_cap_space(req.addr);
  assign hit_csr = in_csr_space(req.addr);
  assign hit_ext = in_ext_space(req.addr);
  assign hit_impl = in_impl_space(req.addr);
  assign resv_hit = !hit_feat && !hit_node && !hit_owner;

  // big-endian bit n sits at vector bit 31-n
  assign feat_word = feat_pack(WIDE_ID_SUPPORT);
  assign node_word = node_pack(short_reg, wide_reg);
  assign owner_word = owner_pack(owner_node_id);

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_next = 32'h0; // reserved registers and spaces read zero
    if (hit_feat) begin
      rdata_next = feat_word;
    end else if (hit_node) begin
      rdata_next = node_word;
    end else if (hit_owner) begin
      rdata_next = owner_word;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid; // every access completes
      rsp.err <= 1'b0; // no error answer exists
      rsp.rdata <= (req.valid && !req.write) ? rdata_next : 32'h0;
    end
  end

  // ****************************************
  // writable fields
  // ****************************************
  // capability space has no write path at all
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      short_reg <= SHORT_ID_RESET;
      wide_reg <= WIDE_ID_RESET;
    end else if (req.valid && req.write && hit_node && !in_cap) begin
      short_reg <= node_short(req.wdata); // reserved bits 31:24 dropped
      wide_reg <= node_wide(req.wdata);
    end
  end

  assign owner_wr = req.valid && req.write && hit_owner;

  tidrb_owner_lock u_owner (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(owner_wr),
    .wr_id(owner_field(req.wdata)),
    .owner_node_id(owner_node_id),
    .lock_state(lock_state)
  );

  // ****************************************
  // status outputs
  // ****************************************
  assign owner_locked = (lock_state == tidrb_pkg::TIDRB_LOCKED);
  assign short_node_id = short_reg;
  assign wide_node_id = wide_reg;
  assign wide_mode = WIDE_ID_SUPPORT; // mirrors WIDE_ID_SUPPORT; both id fields stay active

  // ****************************************
  // checks
  // ****************************************
  a_cap_readonly: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && req.write && in_cap |=> $stable(short_reg) && $stable(wide_reg)
      && $stable(owner_node_id))
    else $error("capability write changed state");
  a_resv_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && !hit_feat && !hit_node && !hit_owner |=> rsp.rdata == 32'h0)
    else $error("reserved register read nonzero");
  a_no_error: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid |=> rsp.valid && !rsp.err)
    else $error("access not completed cleanly");
  a_feat_value: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && hit_feat |=> rsp.rdata == {27'h0, WIDE_ID_SUPPORT, 4'h0})
    else $error("feature word wrong");
  a_node_write: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && req.write && hit_node |=> short_reg == $past(req.wdata[23:16])
      && wide_reg == $past(req.wdata[15:0]))
    else $error("node id write not stored");
  a_node_resv: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && hit_node |=> rsp.rdata[31:24] == 8'h00)
    else $error("node id reserved bits nonzero");
  a_owner_read: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && hit_owner |=> rsp.rdata == {16'h0, $past(owner_node_id)})
    else $error("owner read wrong");
  a_feat_resv: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && hit_feat |=> (rsp.rdata & 32'hffffffef) == 32'h0)
    else $error("feature reserved bits nonzero");
  a_node_read: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && !req.write && hit_node
      |=> rsp.rdata == {8'h00, $past(short_reg), $past(wide_reg)})
    else $error("node id read wrong");
  a_node_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !(req.valid && req.write && hit_node) |=> $stable(short_reg) && $stable(wide_reg))
    else $error("node id changed without its write");
  a_owner_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !owner_wr |=> $stable(owner_node_id))
    else $error("owner changed without its write");
  a_rsp_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    !req.valid |=> !rsp.valid)
    else $error("answer without request");
  a_write_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && req.write |=> rsp.rdata == 32'h0)
    else $error("write answer carried data");
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    !rsp.valid |-> rsp.rdata == 32'h0)
    else $error("idle answer carried data");
  a_resv_write: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && req.write && resv_hit && (hit_csr || hit_ext)
      |=> $stable(short_reg) && $stable(wide_reg) && $stable(owner_node_id))
    else $error("reserved write changed state");
  a_impl_write: assert property (@(posedge mclk) disable iff (!rst_n)
    req.valid && req.write && hit_impl
      |=> $stable(short_reg) && $stable(wide_reg) && $stable(owner_node_id))
    else $error("implementation space write changed state");
  a_reset_ids: assert property (@(posedge mclk)
    !rst_n |=> short_reg == SHORT_ID_RESET && wide_reg == WIDE_ID_RESET)
    else $error("node id reset value wrong");
  // ****************************************
  // covers
  // ****************************************
  c_feat_read: cover property (@(posedge mclk) req.valid && !req.write && hit_feat);
  c_node_write: cover property (@(posedge mclk) req.valid && req.write && hit_node);
  c_resv_access: cover property (@(posedge mclk) req.valid && !hit_feat && !hit_node && !hit_owner);
  c_impl_access: cover property (@(posedge mclk) req.valid && hit_impl);
endmodule : tidrb_regs

//--- tidrb_map.svh
`ifndef TIDRB_MAP_SVH
`define TIDRB_MAP_SVH
// Notes on behaviour
// - reserved bits read zero, writes change nothing
// - reserved registers read zero, writes discarded
// - capability space read-only, writes ignored
// - implementation-defined space behaviour left open
// - registers are aligned 32-bit words
// - capability registers readable by maintenance read
// - big-endian: bit 0 is word msb
// - feature bit 27 reports wide id support
// - node id bits 8-15 hold short id
// - node id bits 16-31 hold wide id
// - node id reset values are parameters
// - owner lock bits 16-31, reset 0xffff
// - locked owner ignores differing writes
// - matching owner write releases to 0xffff
// - undefined offsets complete without error
// - id size selects node id field; here both fields stay live and wide_mode only mirrors WIDE_ID_SUPPORT
// ****************************************
// register offsets and field positions
// ****************************************
`define TIDRB_ADDR_W 24
`define TIDRB_OFS_FEATURE 24'h000010
`define TIDRB_OFS_NODE_ID 24'h000060
`define TIDRB_OFS_OWNER 24'h000068
`define TIDRB_CAP_END 24'h000040
`define TIDRB_EXT_BASE 24'h000100
`define TIDRB_IMPL_BASE 24'h010000
`define TIDRB_FEAT_WIDE_LSB 4
`define TIDRB_SHORT_LSB 16
`define TIDRB_WIDE_LSB 0
`define TIDRB_OWNER_LSB 0
`define TIDRB_OWNER_RESET 16'hffff
`define TIDRB_SHORT_RESET 8'hff
`define TIDRB_WIDE_RESET 16'hffff
`endif

//--- tidrb_pkg.sv
package tidrb_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [31:0] wdata;
  } tidrb_req_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } tidrb_rsp_t;
  typedef enum logic [0:0] {
    TIDRB_UNLOCKED = 1'b0,
    TIDRB_LOCKED = 1'b1
  } tidrb_lock_t;
endpackage : tidrb_pkg

//--- tidrb_owner_lock.sv
`timescale 1ns/1ps
`include "tidrb_map.svh"
module tidrb_owner_lock (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_id,
  output logic [15:0] owner_node_id,
  output tidrb_pkg::tidrb_lock_t lock_state
);
  logic [15:0] owner_reg;
  assign owner_node_id = owner_reg;
  assign lock_state = (owner_reg == `TIDRB_OWNER_RESET) ? tidrb_pkg::TIDRB_UNLOCKED
                                                        : tidrb_pkg::TIDRB_LOCKED;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      owner_reg <= `TIDRB_OWNER_RESET;
    end else if (wr_en) begin
      if (lock_state == tidrb_pkg::TIDRB_UNLOCKED) begin
        owner_reg <= wr_id;
      end else if (wr_id == owner_reg) begin
        owner_reg <= `TIDRB_OWNER_RESET;
      end
      // differing write while held: ignored
    end
  end

  a_lock_ignore: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && lock_state == tidrb_pkg::TIDRB_LOCKED && wr_id != owner_reg
      |=> $stable(owner_reg))
    else $error("owner changed by differing write");
  a_lock_release: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && lock_state == tidrb_pkg::TIDRB_LOCKED && wr_id == owner_reg
      |=> owner_reg == 16'hffff)
    else $error("matching write did not release");
  a_lock_take: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && lock_state == tidrb_pkg::TIDRB_UNLOCKED |=> owner_reg == $past(wr_id))
    else $error("unlocked write not stored");
  c_lock_cycle: cover property (@(posedge mclk) disable iff (!rst_n)
    lock_state == tidrb_pkg::TIDRB_UNLOCKED ##1 lock_state == tidrb_pkg::TIDRB_LOCKED
      ##[1:20] lock_state == tidrb_pkg::TIDRB_UNLOCKED);
endmodule : tidrb_owner_lock

//--- tidrb_host.sv
`timescale 1ns/1ps
// ****************************************
// host issuing maintenance accesses
// ****************************************
module tidrb_host (
  input wire logic mclk,
  input tidrb_pkg::tidrb_rsp_t rsp,
  output tidrb_pkg::tidrb_req_t req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    ok = 1'b0;
    q = 32'h0;
    @(negedge mclk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      // released lines never keep the last value, so stale reads show up
      req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
      if (rsp.valid === 1'b1) begin
        ok = (rsp.err === 1'b0);
        q = rsp.rdata;
        break;
      end
    end
  endtask : xfer
endmodule : tidrb_host

//--- test_transport_id_register_bank.sv
`timescale 1ns/1ps
module test_transport_id_register_bank;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  tidrb_pkg::tidrb_req_t req;
  tidrb_pkg::tidrb_rsp_t rsp;
  logic [7:0] short_node_id;
  logic [15:0] wide_node_id;
  logic [15:0] owner_node_id;
  logic owner_locked;
  logic wide_mode;
  int failures = 0;
  int tests_run = 0;
  logic [23:0] rsv [8] = '{24'h000000, 24'h00003c, 24'h000040, 24'h000064,
                           24'h000070, 24'h0000fc, 24'h000100, 24'h010000};
  always #12.5 mclk = ~mclk;
  tidrb_regs dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .short_node_id(short_node_id), .wide_node_id(wide_node_id),
    .owner_node_id(owner_node_id), .owner_locked(owner_locked), .wide_mode(wide_mode));
  tidrb_host host (.mclk(mclk), .rsp(rsp), .req(req));
  task automatic finish_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    bit ok;
    host.xfer(w, a, d, q, ok);
    tests_run++;
    // a missing answer or an error response ends the run
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask : acc
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [23:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    cmp(q, exp);
  endtask : chk
  task automatic rmw(input logic [23:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    acc(1'b1, a, (q & ~m) | (v & m), q);
  endtask : rmw
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    chk(24'h000010, 32'h00000010);
    chk(24'h000060, 32'h00ffffff);
    chk(24'h000068, 32'h0000ffff);
    wr(24'h000010, 32'hffffffef);
    chk(24'h000010, 32'h00000010);
    foreach (rsv[i]) begin
      wr(rsv[i], 32'hffffffff);
      chk(rsv[i], 32'h00000000);
    end
    chk(24'h000060, 32'h00ffffff);
    chk(24'h000068, 32'h0000ffff);
    wr(24'h000060, 32'hffa51234);
    chk(24'h000060, 32'h00a51234);
    cmp({24'h0, short_node_id}, 32'h000000a5);
    cmp({16'h0, wide_node_id}, 32'h00001234);
    cmp({31'h0, wide_mode}, 32'h00000001);
    chk(24'h000062, 32'h00a51234);
    rmw(24'h000060, 32'h00ff0000, 32'h003c0000);
    chk(24'h000060, 32'h003c1234);
    wr(24'h000068, 32'hffff1234);
    chk(24'h000068, 32'h00001234);
    cmp({31'h0, owner_locked}, 32'h00000001);
    wr(24'h000068, 32'h00005678);
    chk(24'h000068, 32'h00001234);
    wr(24'h000068, 32'h00001234);
    chk(24'h000068, 32'h0000ffff);
    cmp({16'h0, owner_node_id}, 32'h0000ffff);
    cmp({31'h0, owner_locked}, 32'h00000000);
    wr(24'h000068, 32'h00004321);
    chk(24'h000068, 32'h00004321);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    chk(24'h000068, 32'h0000ffff);
    cmp({31'h0, owner_locked}, 32'h00000000);
    chk(24'h000060, 32'h00ffffff);
    finish_test();
  end
endmodule : test_transport_id_register_bank
